// file: include/hbd_pkg.sv
// Package for the H-bridge drive and protection logic.
// Assumes a single 200 MHz system clock; all comparator inputs are digital levels.
package hbd_pkg;
  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Dead interval between switches of one leg, in ns
  localparam int unsigned DEAD_NS = 100;
  localparam int unsigned DEAD_CYC = (DEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Overcurrent retry period, in ns
  localparam int unsigned RETRY_NS = 8000;
  localparam int unsigned RETRY_CYC = (RETRY_NS * 1000) / CLK_PERIOD_PS;
  // Charge-pump oscillator, in Hz; half period in cycles
  localparam int unsigned PUMP_HZ = 300000;
  localparam int unsigned PUMP_HALF_CYC = 1000000000 / (PUMP_HZ / 1000) / (2 * CLK_PERIOD_PS);
  // Reset values
  localparam logic SW_RST = 1'b0;
  localparam logic WARN_OE_RST = 1'b0;
  localparam logic PUMP_CHARGE_RST = 1'b1;

  // Commands to the four switches
  typedef struct packed {
    logic leftHigh;
    logic leftLow;
    logic rightHigh;
    logic rightLow;
  } hbd_switch_t;

  // Analog comparator and supervisor levels
  typedef struct packed {
    logic overCurrent;
    logic thermShutdown;
    logic thermWarn;
    logic underVoltage;
  } hbd_sense_t;

  // Overcurrent cutoff states
  typedef enum logic [0:0] {
    OC_RUN,
    OC_CUTOFF
  } hbd_oc_state_t;
endpackage : hbd_pkg

// file: tb/hbd_ctrl_model.sv
// Controller model: drives PWM, direction and brake, plus a peer warning pull-down.
// Assumes the bench sets command levels; the shared warning line has a pull-up.
`timescale 1ns/1ps
`default_nettype none

module hbd_ctrl_model (
  // Clock
  input wire logic sys_clk,
  // Bench commands
  input wire logic [2:0] cmd,
  input wire logic peerWarn,
  // Device side
  input wire logic devWarnOe,
  output var logic pwmIn,
  output var logic dirIn,
  output var logic brakeIn,
  output logic warnLine
);
  // Levels change only on edges; the bench spaces changes at least seven cycles apart,
  // the switching limit scaled like the shortened counts of the bench
  always @(posedge sys_clk) begin
    {pwmIn, dirIn, brakeIn} <= cmd;
  end
  // Pulled-up shared line: low while any device pulls
  assign warnLine = ~(devWarnOe | peerWarn);
endmodule // hbd_ctrl_model

`default_nettype wire

// file: tb/hbd_drive_logic_bench.sv
// Self-checking bench for the H-bridge drive and protection logic.
// Assumes shortened counts: dead 2, retry 8, pump half period 4 cycles.
`timescale 1ns/1ps
`default_nettype none

module hbd_drive_logic_bench;
  localparam int DC = 2;
  localparam int RC = 8;
  localparam int PH = 4;
  logic sys_clk, arst_n, peerWarn, pwmIn, dirIn, brakeIn, warnLine;
  logic warnOut, warnOe, pumpChargePhase, pumpLiftPhase;
  logic [2:0] cmd;
  hbd_pkg::hbd_sense_t senseIn;
  hbd_pkg::hbd_switch_t switchOut;
  int fails, n_tests;

  ////////////////////////////////////////////////////////////////////////
  // Clock, instances
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  hbd_drive_logic #(.DEAD_CYCLES(DC), .RETRY_CYCLES(RC), .PUMP_HALF_CYCLES(PH)) i_hbd_drive_logic (
    .sys_clk(sys_clk), .arst_n(arst_n), .pwmIn(pwmIn), .dirIn(dirIn), .brakeIn(brakeIn),
    .senseIn(senseIn), .switchOut(switchOut), .pumpChargePhase(pumpChargePhase),
    .pumpLiftPhase(pumpLiftPhase), .warnLineIn(warnLine), .warnOut(warnOut), .warnOe(warnOe));
  hbd_ctrl_model i_hbd_ctrl_model (.sys_clk(sys_clk), .cmd(cmd), .peerWarn(peerWarn),
    .devWarnOe(warnOe), .pwmIn(pwmIn), .dirIn(dirIn), .brakeIn(brakeIn), .warnLine(warnLine));

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic drive(input logic [2:0] c, input hbd_pkg::hbd_sense_t s);
    @(posedge sys_clk);
    cmd <= c;
    senseIn <= s;
  endtask
  task automatic cmp_sw(input hbd_pkg::hbd_switch_t exp, input string msg);
    n_tests++;
    if (switchOut !== exp) begin
      fails++;
      $display("FAIL %0t %s: got %b exp %b", $time, msg, switchOut, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s: got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_truth;
    logic [2:0] tc [8] = '{3'h6, 3'h4, 3'h0, 3'h2, 3'h7, 3'h5, 3'h1, 3'h3};
    logic [3:0] te [8] = '{4'h9, 4'h6, 4'ha, 4'ha, 4'ha, 4'h5, 4'h0, 4'h0};
    for (int i = 0; i < 8; i++) begin
      drive(tc[i], '0);
      cyc(10);
      cmp_sw(te[i], "decode");
    end
    $display("test truth done");
  endtask
  task automatic t_dead;
    int off;
    logic bad;
    off = 0;
    bad = 1'b0;
    drive(3'h0, '0);
    cyc(10);
    drive(3'h6, '0);
    for (int i = 0; i < 30 && switchOut.rightLow !== 1'b1; i++) begin
      cyc(1);
      bad |= (switchOut.rightHigh & switchOut.rightLow) | (switchOut.leftHigh & switchOut.leftLow);
      if (!switchOut.rightHigh && !switchOut.rightLow) off++;
    end
    cmp_bit(bad, 1'b0, "shoot through");
    cmp_bit(off >= DC, 1'b1, "dead interval short");
    cmp_sw(4'h9, "after dead");
    $display("test dead done");
  endtask
  task automatic t_overcur(input logic [2:0] c, input logic [3:0] on, input logic [3:0] cut);
    drive(c, '0);
    cyc(10);
    drive(c, 4'h8);
    cyc(6);
    cmp_sw(cut, "trip");
    drive(c, '0);
    cyc(3);
    cmp_sw(cut, "hold in retry");
    cyc(2 * RC + 7);
    cmp_sw(on, "retry");
    $display("test overcurrent done");
  endtask
  task automatic t_fault(input hbd_pkg::hbd_sense_t s);
    drive(3'h6, '0);
    cyc(10);
    drive(3'h6, s);
    cyc(6);
    cmp_sw(4'h0, "fault off");
    drive(3'h6, s & 4'h1);
    cyc(8);
    cmp_sw(s[0] ? 4'h0 : 4'h9, "other fault");
    drive(3'h6, '0);
    cyc(10 + DC);
    cmp_sw(4'h9, "resume");
    $display("test fault done");
  endtask
  task automatic t_warn;
    drive(3'h6, 4'h2);
    cyc(6);
    cmp_bit(warnOe, 1'b1, "warn pull");
    cmp_bit(warnOut, 1'b0, "warn data");
    cmp_bit(warnLine, 1'b0, "warn line");
    drive(3'h6, '0);
    cyc(6);
    cmp_bit(warnOe, 1'b0, "warn release");
    cmp_bit(warnLine, 1'b1, "line idle");
    @(posedge sys_clk);
    peerWarn <= 1'b1;
    #1;
    cmp_bit(warnLine, 1'b0, "peer warn");
    @(posedge sys_clk);
    peerWarn <= 1'b0;
    $display("test warn done");
  endtask
  task automatic t_pump;
    int tog;
    logic prev, bad;
    tog = 0;
    bad = 1'b0;
    drive(3'h7, '0);
    cyc(10);
    prev = pumpChargePhase;
    for (int i = 0; i < 80; i++) begin
      cyc(1);
      bad |= (pumpLiftPhase !== ~pumpChargePhase);
      if (pumpChargePhase !== prev) tog++;
      prev = pumpChargePhase;
    end
    cmp_bit(bad, 1'b0, "pump phases");
    cmp_bit(tog >= 80 / PH - 1 && tog <= 80 / PH + 1, 1'b1, "pump rate");
    cmp_sw(4'ha, "highs held");
    $display("test pump done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    arst_n = 1'b0;
    cmd = 3'h0;
    senseIn = '0;
    peerWarn = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    cmp_sw(4'h0, "reset switches");
    cmp_bit(pumpChargePhase, 1'b1, "reset pump");
    cmp_bit(pumpLiftPhase, 1'b0, "reset lift");
    cmp_bit(warnOe, 1'b0, "reset warn");
    t_truth();
    t_dead();
    t_overcur(3'h7, 4'ha, 4'h0);
    t_overcur(3'h4, 4'h6, 4'h4);
    t_fault(4'h4);
    t_fault(4'h1);
    t_fault(4'h5);
    t_warn();
    t_pump();
    tally_and_finish();
  end
  initial begin
    cyc(20000);
    fails++;
    tally_and_finish();
  end
endmodule // hbd_drive_logic_bench

`default_nettype wire

// file: verilog/hbd_drive_logic.sv
// H-bridge input decoding, dead interval, protections and charge-pump clock.
// Assumes asynchronous inputs from the controller and from analog comparators;
// each passes a two-flop synchroniser. The comparator for thermal shutdown
// carries the analog hysteresis itself.
`timescale 1ns/1ps
`default_nettype none

module hbd_drive_logic #(
  parameter int unsigned DEAD_CYCLES = hbd_pkg::DEAD_CYC,
  parameter int unsigned RETRY_CYCLES = hbd_pkg::RETRY_CYC,
  parameter int unsigned PUMP_HALF_CYCLES = hbd_pkg::PUMP_HALF_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Controller inputs
  input wire logic pwmIn,
  input wire logic dirIn,
  input wire logic brakeIn,
  // Comparator and supervisor levels
  input wire hbd_pkg::hbd_sense_t senseIn,
  // Switch gate commands
  output var hbd_pkg::hbd_switch_t switchOut,
  // Charge-pump phases
  output logic pumpChargePhase,
  output logic pumpLiftPhase,
  // Open-collector warning: line level in, pull-down enable out, data always low
  input wire logic warnLineIn,
  output logic warnOut,
  output logic warnOe
);

  // Elaboration-time checks
  if (DEAD_CYCLES < 1 || DEAD_CYCLES > 255) begin : g_chk_dead
    $error("DEAD_CYCLES out of range");
  end
  if (RETRY_CYCLES < 2 || RETRY_CYCLES > 65535) begin : g_chk_retry
    $error("RETRY_CYCLES out of range");
  end
  if (PUMP_HALF_CYCLES < 1 || PUMP_HALF_CYCLES > 65535) begin : g_chk_pump
    $error("PUMP_HALF_CYCLES out of range");
  end

  localparam logic [7:0] DEAD_LAST = 8'(DEAD_CYCLES - 1);
  localparam logic [15:0] RETRY_LAST = 16'(RETRY_CYCLES - 1);
  localparam logic [15:0] PUMP_LAST = 16'(PUMP_HALF_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [6:0] syncA;
  logic [6:0] syncB;
  logic pwm, dir, brake, ocTrip, thermOff, thermWarn, underV;

  // Two flops for every controller and comparator level
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 7'h00;
      syncB <= 7'h00;
    end else begin
      syncA <= {pwmIn, dirIn, brakeIn, senseIn};
      syncB <= syncA;
    end
  end

  assign {pwm, dir, brake, ocTrip, thermOff, thermWarn, underV} = syncB;

  ////////////////////////////////////////////////////////////////////////////
  // Input decoding
  hbd_pkg::hbd_switch_t decoded;

  // Truth table of the three logic inputs
  always_comb begin
    decoded = '0;
    if (!brake) begin
      if (pwm && dir) begin
        decoded.leftHigh = 1'b1;
        decoded.rightLow = 1'b1;
      end else if (pwm) begin
        decoded.leftLow = 1'b1;
        decoded.rightHigh = 1'b1;
      end else begin
        decoded.leftHigh = 1'b1;
        decoded.rightHigh = 1'b1;
      end
    end else if (pwm && dir) begin
      decoded.leftHigh = 1'b1;
      decoded.rightHigh = 1'b1;
    end else if (pwm) begin
      decoded.leftLow = 1'b1;
      decoded.rightLow = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent cutoff with periodic retry
  hbd_pkg::hbd_oc_state_t ocState, next_ocState;
  logic [15:0] retryCnt, next_retryCnt;
  logic highWanted;

  assign highWanted = decoded.leftHigh | decoded.rightHigh;

  // Cutoff holds for the retry period, then re-enables if still commanded
  always_comb begin
    next_ocState = ocState;
    next_retryCnt = retryCnt;
    unique case (ocState)
      hbd_pkg::OC_RUN: begin
        next_retryCnt = 16'h0000;
        if (ocTrip) begin
          next_ocState = hbd_pkg::OC_CUTOFF;
        end
      end
      hbd_pkg::OC_CUTOFF: begin
        if (retryCnt == RETRY_LAST) begin
          next_retryCnt = 16'h0000;
          if (highWanted) begin
            next_ocState = hbd_pkg::OC_RUN;
          end
        end else begin
          next_retryCnt = retryCnt + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ocState <= hbd_pkg::OC_RUN;
      retryCnt <= 16'h0000;
    end else begin
      ocState <= next_ocState;
      retryCnt <= next_retryCnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault gating after decoding
  hbd_pkg::hbd_switch_t gated;
  logic allOff, highOff;

  // Thermal and supply faults kill all four; overcurrent only the high side
  always_comb begin
    allOff = thermOff | underV;
    highOff = allOff | ocTrip | (ocState == hbd_pkg::OC_CUTOFF);
    gated = decoded;
    if (allOff) begin
      gated = '0;
    end
    if (highOff) begin
      gated.leftHigh = 1'b0;
      gated.rightHigh = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dead interval per leg
  logic [7:0] deadLeft, next_deadLeft, deadRight, next_deadRight;
  hbd_pkg::hbd_switch_t next_switchOut;

  // A leg that changes which switch is on spends DEAD_CYCLES with both off
  always_comb begin
    next_deadLeft = deadLeft;
    next_deadRight = deadRight;
    next_switchOut = gated;
    if (deadLeft != 8'h00) begin
      next_deadLeft = deadLeft - 8'h01;
      next_switchOut.leftHigh = 1'b0;
      next_switchOut.leftLow = 1'b0;
    end else if ((gated.leftHigh && switchOut.leftLow) || (gated.leftLow && switchOut.leftHigh)) begin
      next_deadLeft = DEAD_LAST;
      next_switchOut.leftHigh = 1'b0;
      next_switchOut.leftLow = 1'b0;
    end
    if (deadRight != 8'h00) begin
      next_deadRight = deadRight - 8'h01;
      next_switchOut.rightHigh = 1'b0;
      next_switchOut.rightLow = 1'b0;
    end else if ((gated.rightHigh && switchOut.rightLow) || (gated.rightLow && switchOut.rightHigh)) begin
      next_deadRight = DEAD_LAST;
      next_switchOut.rightHigh = 1'b0;
      next_switchOut.rightLow = 1'b0;
    end
    // Faults cut immediately, even inside a dead interval
    if (allOff) begin
      next_switchOut = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      deadLeft <= 8'h00;
      deadRight <= 8'h00;
      switchOut <= {4{hbd_pkg::SW_RST}};
    end else begin
      deadLeft <= next_deadLeft;
      deadRight <= next_deadRight;
      switchOut <= next_switchOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge-pump oscillator, free running
  logic [15:0] pumpCnt, next_pumpCnt;
  logic next_pumpCharge;

  // Toggles the two phases every half period, never stopping
  always_comb begin
    next_pumpCnt = pumpCnt + 16'h0001;
    next_pumpCharge = pumpChargePhase;
    if (pumpCnt == PUMP_LAST) begin
      next_pumpCnt = 16'h0000;
      next_pumpCharge = !pumpChargePhase;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pumpCnt <= 16'h0000;
      pumpChargePhase <= hbd_pkg::PUMP_CHARGE_RST;
      pumpLiftPhase <= !hbd_pkg::PUMP_CHARGE_RST;
    end else begin
      pumpCnt <= next_pumpCnt;
      pumpChargePhase <= next_pumpCharge;
      pumpLiftPhase <= !next_pumpCharge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-collector thermal warning
  logic next_warnOe;

  // The shared line level is not needed here: our pull-down depends only on our own sensor
  // Pull-down only; data is a constant low
  always_comb begin
    next_warnOe = thermWarn;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      warnOe <= hbd_pkg::WARN_OE_RST;
      warnOut <= 1'b0;
    end else begin
      warnOe <= next_warnOe;
      warnOut <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_leg_left_swap;
    switchOut.leftHigh ##1 !switchOut.leftHigh;
  endsequence

  sequence s_leg_right_swap;
    switchOut.rightHigh ##1 !switchOut.rightHigh;
  endsequence

  a_left_shoot: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(switchOut.leftHigh && switchOut.leftLow)) else $error("Left leg shoot-through");
  a_right_shoot: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(switchOut.rightHigh && switchOut.rightLow)) else $error("Right leg shoot-through");
  a_left_dead_gap: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_leg_left_swap |-> !switchOut.leftLow) else $error("Left low on without dead gap");
  a_right_dead_gap: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_leg_right_swap |-> !switchOut.rightLow) else $error("Right low on without dead gap");
  a_fault_all_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    allOff |=> (switchOut == '0)) else $error("Switch on during fault");
  a_uv_all_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    underV |=> (switchOut == '0)) else $error("Switch on in undervoltage");
  a_oc_high_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ocTrip |=> !switchOut.leftHigh && !switchOut.rightHigh) else $error("High on in overcurrent");
  a_oc_retry_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ocState == hbd_pkg::OC_RUN) ##1 (ocState == hbd_pkg::OC_CUTOFF) |-> (retryCnt == 16'h0000))
    else $error("Retry count not restarted");
  a_cutoff_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ocState == hbd_pkg::OC_CUTOFF) |=> !switchOut.leftHigh && !switchOut.rightHigh)
    else $error("High on during cutoff");
  a_brake_coast: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (brake && !pwm) |=> (switchOut == '0)) else $error("Brake coast decode wrong");
  a_pump_alternate: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ##1 (pumpChargePhase != pumpLiftPhase)) else $error("Pump phases overlap");
  a_warn_no_drive: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !warnOut && (warnOe == $past(thermWarn))) else $error("Warning output wrong");

endmodule : hbd_drive_logic

`default_nettype wire
